// file: logic/pwr_reset_cfg.svh
`ifndef PWR_RESET_CFG_SVH
`define PWR_RESET_CFG_SVH

// Register offsets (byte addresses; E0 is in configuration space, the rest in the device's I/O window).
`define OFF_INTERRUPT_STATUS 8'h04
`define OFF_INTERRUPT_MASK   8'h08
`define OFF_GENERAL_CONTROL  8'h0C
`define OFF_POWER_MGMT_CTRL_STATUS_CFG        8'hE0

// General control fields.
`define GC_SOFT_RESET_BIT    0
`define GC_POWER_DOWN_BIT    3
`define GC_CLK_RESTORE_BIT   16
`define GC_RST_IGNORE_BIT    17
`define GC_WAKE_PKT_EN_BIT   18
`define GC_WAKE_INT_EN_BIT   19
`define GC_RST_EFFECT_LO     20
`define GC_RST_EFFECT_HI     21
`define GC_SPECIAL_MODE_BIT  22

// Interrupt status and mask fields.
`define IS_WAKE_BIT          14

// Power management control/status fields.
`define PM_STATE_LO          0
`define PM_STATE_HI          1
`define PM_WAKE_EN_BIT       8
`define PM_WAKE_STS_BIT      15

// Reset values.
`define GC_RESET_VAL         32'h0000_0008
`define IM_RESET_VAL         32'h0000_0000
`define PM_STATE_D0          2'h0
`define PM_STATE_D3          2'h3

// Resource window sizes in bytes.
`define IO_WINDOW_BYTES      32'h0000_0100
`define MEM_WINDOW_BYTES     32'h0000_1000
`define ROM_WINDOW_BYTES     32'h0001_0000

// Soft reset time in clock cycles.
`define SOFT_RESET_CLOCKS    15
`define SOFT_CNT_W           4

`endif

// file: logic/pwr_reset_pkg.sv
package pwr_reset_pkg;

  typedef enum logic [1:0] {
    rst_effect_assert,
    rst_effect_release,
    rst_effect_none,
    rst_effect_none2
  } rst_effect_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        cfg;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        sys_clk_en;
    logic        mac_clk_en;
    logic        soft_reset;
    logic        func_enable;
  } pwr_ctl_t;

endpackage

// file: logic/pin_sync.sv
`timescale 1ns/10ps
// Three-stage synchronizer; a change counts once stages two and three agree.
module pin_sync #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pin
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg    <= INIT;
      s2_reg    <= INIT;
      s3_reg    <= INIT;
      level_out <= INIT;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end

endmodule

// file: logic/ethernet_power_reset_manager.sv
`timescale 1ns/10ps
`include "pwr_reset_cfg.svh"

// Function
// - Effect 00: bus reset assert forces D0
// - Effect 01: bus reset release forces D0
// - Effect 10/11: bus reset leaves state
// - Reset-ignore bit masks all bus reset
// - Clock-restore bit keeps system clock running
// - Wake interrupt needs enable and mask
// - Wake interrupt clears only via status
// - Power-on reset clears wake bits, D0
// - Special mode zero at power-up, retained
// - Low power-good means bus power lost
// - Power-good return moves D3cold to D0
// - Power-down gates system clock; MAC clock only in loopback
// - Powered down: only config and control
// - Hard reset pin enters power-down
// - Clearing power-down wakes; stays after reset
// - Power-down never gates bus clock
// - Soft reset spares configuration registers
// - Soft reset lasts fifteen clocks
// - Requests I/O, memory, ROM windows
// - Wake output follows status and enable
// - Bus reset spares wake bits
module ethernet_power_reset_manager
  import pwr_reset_pkg::*;
#(
  parameter int SOFT_CLOCKS = `SOFT_RESET_CLOCKS
) (
  // Clock and power-on reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Board pins
  input  wire logic        hard_reset_in_n,
  input  wire logic        pci_reset_in_n,
  input  wire logic        bus_power_good_in,
  // Register access
  input  wire reg_req_t    req,
  output logic [31:0]      rdata,
  output logic             ack,
  // Wake sources and status
  input  wire logic        wake_event_in,
  input  wire logic        loopback_active,
  // Outputs
  output logic             wake_event_out_n,
  output logic             inta_n,
  output pwr_ctl_t         ctl,
  output logic [1:0]       power_state,
  output logic             d3_cold,
  output logic [31:0]      io_window_size,
  output logic [31:0]      mem_window_size,
  output logic [31:0]      rom_window_size
);

  // ----------------------------------------------------------------
  // Pin synchronization
  // ----------------------------------------------------------------
  logic pci_rst_n_s;
  logic pgood_s;
  logic hard_rst_n_s;
  logic pci_rst_n_d;
  logic pgood_d;
  logic hard_rst_n_d;

  pin_sync #(.INIT(1'b1)) u_sync_pcirst (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (pci_reset_in_n),
    .level_out (pci_rst_n_s)
  );

  pin_sync #(.INIT(1'b0)) u_sync_pgood (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (bus_power_good_in),
    .level_out (pgood_s)
  );

  pin_sync #(.INIT(1'b1)) u_sync_hardrst (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (hard_reset_in_n),
    .level_out (hard_rst_n_s)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pci_rst_n_d  <= 1'b1;
      pgood_d      <= 1'b0;
      hard_rst_n_d <= 1'b1;
    end else begin
      pci_rst_n_d  <= pci_rst_n_s;
      pgood_d      <= pgood_s;
      hard_rst_n_d <= hard_rst_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Edge events
  // ----------------------------------------------------------------
  logic [31:0] gc_reg;
  logic [31:0] im_reg;
  logic        pm_wake_sts_reg;
  logic        pm_wake_en_reg;
  logic [1:0]  pm_state_reg;
  logic        special_reg;
  logic        cold_reg;
  logic        soft_busy_reg;
  logic [`SOFT_CNT_W-1:0] soft_cnt_reg;
  rst_effect_t effect;
  logic        rst_ignore;
  logic        bus_rst_fall;
  logic        bus_rst_rise;
  logic        pgood_lost;
  logic        pgood_back;
  logic        hard_rst_fall;
  logic        powered_down;

  assign effect        = rst_effect_t'(gc_reg[`GC_RST_EFFECT_HI:`GC_RST_EFFECT_LO]);
  assign rst_ignore    = gc_reg[`GC_RST_IGNORE_BIT];
  assign bus_rst_fall  = pci_rst_n_d & ~pci_rst_n_s & ~rst_ignore;
  assign bus_rst_rise  = ~pci_rst_n_d & pci_rst_n_s & ~rst_ignore;
  assign pgood_lost    = pgood_d & ~pgood_s;
  assign pgood_back    = ~pgood_d & pgood_s;
  assign hard_rst_fall = hard_rst_n_d & ~hard_rst_n_s;
  assign powered_down  = gc_reg[`GC_POWER_DOWN_BIT];

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  logic wr_cfg;
  logic wr_gc;
  logic wr_im;
  logic io_ok;

  // While powered down only config and control respond; in soft reset only config responds.
  assign io_ok  = ~soft_busy_reg & (~powered_down | (req.addr == `OFF_GENERAL_CONTROL));
  assign wr_cfg = req.wr & req.cfg & (req.addr == `OFF_POWER_MGMT_CTRL_STATUS_CFG);
  assign wr_gc  = req.wr & ~req.cfg & ~soft_busy_reg & (req.addr == `OFF_GENERAL_CONTROL);
  assign wr_im  = req.wr & ~req.cfg & io_ok & (req.addr == `OFF_INTERRUPT_MASK);

  // ----------------------------------------------------------------
  // General control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gc_reg <= `GC_RESET_VAL;
    end else if (hard_rst_fall) begin
      gc_reg <= (gc_reg & (32'h1 << `GC_SPECIAL_MODE_BIT)) | `GC_RESET_VAL;
    end else if (wr_gc) begin
      gc_reg <= req.wdata;
      if (~req.wdata[`GC_POWER_DOWN_BIT] == 1'b0) begin
        gc_reg[`GC_SOFT_RESET_BIT] <= 1'b0;
      end
    end else begin
      gc_reg[`GC_SOFT_RESET_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Soft reset timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_busy_reg <= 1'b0;
      soft_cnt_reg  <= '0;
    end else if (wr_gc & req.wdata[`GC_SOFT_RESET_BIT] & ~powered_down) begin
      soft_busy_reg <= 1'b1;
      soft_cnt_reg  <= `SOFT_CNT_W'(SOFT_CLOCKS - 1);
    end else if (soft_busy_reg) begin
      if (soft_cnt_reg == '0) begin
        soft_busy_reg <= 1'b0;
      end else begin
        soft_cnt_reg <= soft_cnt_reg - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      im_reg <= `IM_RESET_VAL;
    end else if (hard_rst_fall) begin
      im_reg <= `IM_RESET_VAL;
    end else if (wr_im) begin
      im_reg <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Wake status and enable (no reset but power-on reset clears them)
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pm_wake_sts_reg <= 1'b0;
      pm_wake_en_reg  <= 1'b0;
    end else begin
      if (wr_cfg) begin
        pm_wake_en_reg <= req.wdata[`PM_WAKE_EN_BIT];
      end
      // A new event wins over a write-one-to-clear in the same cycle.
      if (wake_event_in & (pm_state_reg != `PM_STATE_D0)) begin
        pm_wake_sts_reg <= 1'b1;
      end else if (wr_cfg & req.wdata[`PM_WAKE_STS_BIT]) begin
        pm_wake_sts_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pm_state_reg <= `PM_STATE_D0;
      cold_reg     <= 1'b0;
    end else if (special_reg & pgood_lost) begin
      pm_state_reg <= `PM_STATE_D3;
      cold_reg     <= 1'b1;
    end else if (special_reg & pgood_back & cold_reg) begin
      pm_state_reg <= `PM_STATE_D0;
      cold_reg     <= 1'b0;
    end else if (bus_rst_fall & (effect == rst_effect_assert)) begin
      pm_state_reg <= `PM_STATE_D0;
    end else if (bus_rst_rise & (effect == rst_effect_release)) begin
      pm_state_reg <= `PM_STATE_D0;
    end else if (wr_cfg) begin
      pm_state_reg <= req.wdata[`PM_STATE_HI:`PM_STATE_LO];
    end
    // Effects 10 and 11 fall through with no change.
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      special_reg <= 1'b0;
    end else if (wr_gc) begin
      special_reg <= req.wdata[`GC_SPECIAL_MODE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic low_power;
  logic [31:0] is_val;
  logic [31:0] gc_val;

  assign low_power = (pm_state_reg != `PM_STATE_D0);
  assign is_val    = 32'(pm_wake_sts_reg) << `IS_WAKE_BIT;
  assign gc_val    = {gc_reg[31:23], special_reg, gc_reg[21:0]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
      ack   <= 1'b0;
    end else begin
      ack   <= req.rd | req.wr;
      rdata <= '0;
      if (req.rd & req.cfg & (req.addr == `OFF_POWER_MGMT_CTRL_STATUS_CFG)) begin
        rdata <= (32'(pm_wake_sts_reg) << `PM_WAKE_STS_BIT) | (32'(pm_wake_en_reg) << `PM_WAKE_EN_BIT)
                 | 32'(pm_state_reg);
      end else if (req.rd & ~req.cfg & io_ok) begin
        case (req.addr)
          `OFF_INTERRUPT_STATUS: rdata <= is_val;
          `OFF_INTERRUPT_MASK:   rdata <= im_reg;
          `OFF_GENERAL_CONTROL:  rdata <= gc_val;
          default:               rdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_event_out_n <= 1'b1;
      inta_n           <= 1'b1;
      ctl              <= '0;
    end else begin
      wake_event_out_n <= ~(pm_wake_sts_reg & pm_wake_en_reg);
      inta_n           <= ~(low_power & pm_wake_sts_reg & gc_reg[`GC_WAKE_INT_EN_BIT]
                            & im_reg[`IS_WAKE_BIT]);
      ctl.sys_clk_en   <= ~(powered_down | low_power) | gc_reg[`GC_CLK_RESTORE_BIT];
      ctl.mac_clk_en   <= ~(powered_down & loopback_active);
      ctl.soft_reset   <= soft_busy_reg;
      ctl.func_enable  <= ~powered_down & ~soft_busy_reg;
    end
  end

  assign power_state     = pm_state_reg;
  assign d3_cold         = cold_reg;
  assign io_window_size  = `IO_WINDOW_BYTES;
  assign mem_window_size = `MEM_WINDOW_BYTES;
  assign rom_window_size = `ROM_WINDOW_BYTES;

endmodule

// file: tb/ethernet_power_reset_manager_asserts.sv
`timescale 1ns/10ps
module epr_checker
  import pwr_reset_pkg::*;
#(
  parameter int SOFT_CLOCKS = 15
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Pins and bus
  input  wire logic        hard_reset_in_n,
  input  wire logic        bus_power_good_in,
  input  wire reg_req_t    req,
  input  wire logic [31:0] rdata,
  input  wire logic        ack,
  // Outputs
  input  wire pwr_ctl_t    ctl,
  input  wire logic [1:0]  power_state,
  input  wire logic        d3_cold,
  input  wire logic [31:0] io_window_size,
  input  wire logic [31:0] mem_window_size,
  input  wire logic [31:0] rom_window_size
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int cnt;
  // Counts the cycles that soft reset stands.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
    end else begin
      cnt <= ctl.soft_reset ? cnt + 1 : 0;
    end
  end
  // A control write counts only if soft reset was not running when it was taken.
  sequence gc_wr(bit pd, bit cr);
    req.wr && !req.cfg && req.addr == 8'h0C && req.wdata[3] == pd && req.wdata[16] == cr
    ##1 !ctl.soft_reset;
  endsequence
  // An I/O read; the registered outputs one cycle later show whether it was refused.
  sequence io_read;
    req.rd && !req.cfg;
  endsequence
  sequence io_refused;
    io_read ##1 (ctl.soft_reset || (!ctl.func_enable && $past(req.addr) != 8'h0C));
  endsequence
  sequence pg_return;
    $rose(bus_power_good_in) && d3_cold;
  endsequence
  ack_pulse_a: assert property ((req.rd || req.wr) |=> ack)
    else $error("ack missing after request");
  ack_idle_a: assert property (!(req.rd || req.wr) |=> !ack)
    else $error("ack without request");
  windows_fixed_a: assert property (io_window_size == 32'h100 && mem_window_size == 32'h1000 && rom_window_size == 32'h10000)
    else $error("window size wrong");
  clk_gate_a: assert property (gc_wr(1'b1, 1'b0) |=> !ctl.sys_clk_en)
    else $error("system clock not gated");
  clk_keep_a: assert property (gc_wr(1'b1, 1'b1) |=> ctl.sys_clk_en)
    else $error("system clock not kept");
  soft_len_a: assert property ($fell(ctl.soft_reset) |-> cnt == SOFT_CLOCKS || cnt == SOFT_CLOCKS + 1)
    else $error("soft reset length wrong");
  refused_rd_a: assert property (io_refused |-> rdata == 32'h0)
    else $error("refused read returned data");
  power_back_a: assert property (pg_return |-> ##[1:8] (!d3_cold && power_state == 2'h0))
    else $error("no return to D0");
  hard_pd_a: assert property ($fell(hard_reset_in_n) |-> ##[1:8] !ctl.func_enable)
    else $error("hard reset left device up");
endmodule

bind ethernet_power_reset_manager epr_checker #(.SOFT_CLOCKS(SOFT_CLOCKS)) u_chk (
  .clk(clk), .rst(rst), .hard_reset_in_n(hard_reset_in_n), .bus_power_good_in(bus_power_good_in),
  .req(req), .rdata(rdata), .ack(ack), .ctl(ctl), .power_state(power_state), .d3_cold(d3_cold),
  .io_window_size(io_window_size), .mem_window_size(mem_window_size), .rom_window_size(rom_window_size));

// file: tb/host_driver_model.sv
`timescale 1ns/10ps
module host_driver_model
  import pwr_reset_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Register bus
  output reg_req_t         req,
  input  wire logic        ack,
  input  wire logic [31:0] rdata
);
  int timeouts = 0;
  initial req = '0;
  // One-clock request, then a bounded wait for the answer.
  task automatic xfer(input logic rd, input logic cfg, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    req = {!rd, rd, cfg, a, d};
    @(posedge clk);
    #1 req = '0;
    for (n = 0; n < 4 && ack !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 4) timeouts++;
    q = rdata;
    // An idle cycle keeps two requests from being driven in one time step.
    @(posedge clk);
    #1;
  endtask
endmodule

// file: tb/ethernet_power_reset_manager_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module ethernet_power_reset_manager_bench;
  import pwr_reset_pkg::*;
  logic        clk = 0, rst = 1, hrst_n = 1, prst_n = 1, pgood = 1, wake_in = 0, loop_act = 0;
  reg_req_t    req;
  logic [31:0] rdata, q;
  logic        ack, wake_n, inta_n, d3c;
  logic [1:0]  pst;
  pwr_ctl_t    ctl;
  int          fail_count = 0, comparisons = 0, m_gc, m_mask, eff, ign, k;

  ethernet_power_reset_manager #(.SOFT_CLOCKS(15)) u_dut (
    .clk(clk), .rst(rst), .hard_reset_in_n(hrst_n), .pci_reset_in_n(prst_n), .bus_power_good_in(pgood),
    .req(req), .rdata(rdata), .ack(ack), .wake_event_in(wake_in), .loopback_active(loop_act),
    .wake_event_out_n(wake_n), .inta_n(inta_n), .ctl(ctl), .power_state(pst), .d3_cold(d3c),
    .io_window_size(), .mem_window_size(), .rom_window_size());
  host_driver_model u_host (.clk(clk), .req(req), .ack(ack), .rdata(rdata));

  initial forever #20 clk = ~clk;

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic cfg, logic [7:0] a, logic [31:0] d);
    u_host.xfer(1'b0, cfg, a, d, q);
  endtask
  task automatic rd(logic cfg, logic [7:0] a);
    u_host.xfer(1'b1, cfg, a, 32'h0, q);
  endtask
  task automatic give_verdict;
    fail_count += u_host.timeouts;
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h714db49d));
    repeat (8) @(posedge clk);
    #1 rst = 0;
    cyc(1);
    m_gc = 32'h8;
    m_mask = $urandom;
    rd(0, 8'h0C); `CHK("gc", m_gc, q)
    `CHK("state", 2'h0, pst)
    rd(1, 8'hE0); `CHK("pm", 32'h0, q & 32'h8103)
    rd(0, 8'h08); `CHK("pd read", 32'h0, q)
    wr(0, 8'h0C, 32'h0); cyc(1); `CHK("up", 1'b1, ctl.func_enable)
    wr(0, 8'h08, m_mask);
    wr(0, 8'h0C, 32'h1);
    for (k = 0; k < 40 && ctl.soft_reset === 1'b1; k++) cyc(1);
    `CHK("soft len", 15, k)
    rd(0, 8'h08); `CHK("mask kept", m_mask, q)
    rd(0, 8'h0C); `CHK("pd clear", 32'h0, q & 32'h8)
    rd(0, 8'h40); `CHK("unmapped", 32'h0, q)
    wr(0, 8'h08, 32'h4000);
    for (k = 0; k < 5; k++) begin
      eff = k % 4;
      ign = (k == 4);
      wr(0, 8'h0C, (eff << 20) | (ign << 17) | 32'h80000);
      wr(1, 8'hE0, 32'h103);
      wake_in = 1;
      cyc(1);
      wake_in = 0;
      cyc(6);
      `CHK("wake out", 1'b0, wake_n)
      `CHK("inta", 1'b0, inta_n)
      wr(0, 8'h04, 32'h4000); cyc(2); `CHK("inta kept", 1'b0, inta_n)
      rd(0, 8'h04); `CHK("is wake", 32'h4000, q)
      prst_n = 0;
      cyc(8);
      `CHK("state rst", (!ign && eff == 0) ? 2'h0 : 2'h3, pst)
      prst_n = 1;
      cyc(8);
      `CHK("state rel", (!ign && eff < 2) ? 2'h0 : 2'h3, pst)
      `CHK("wake kept", 1'b0, wake_n)
      wr(1, 8'hE0, 32'h8000); cyc(2);
      `CHK("wake clr", 1'b1, wake_n)
      `CHK("inta clr", 1'b1, inta_n)
    end
    wr(0, 8'h08, 32'h0);
    wr(0, 8'h0C, 32'h80000);
    wr(1, 8'hE0, 32'h103);
    wake_in = 1;
    cyc(1);
    wake_in = 0;
    cyc(6);
    `CHK("inta masked", 1'b1, inta_n)
    wr(0, 8'h0C, 32'h8);
    rd(0, 8'h04); `CHK("pd status", 32'h0, q)
    wr(0, 8'h08, 32'h4000);
    wr(0, 8'h0C, 32'h0);
    rd(0, 8'h08); `CHK("pd mask wr", 32'h0, q)
    wr(0, 8'h08, 32'h4000); cyc(2);
    `CHK("inta no enable", 1'b1, inta_n)
    wr(1, 8'hE0, 32'h8000); cyc(2);
    wr(0, 8'h0C, 32'h400000);
    pgood = 0;
    cyc(8);
    `CHK("cold", 1'b1, d3c)
    pgood = 1;
    cyc(8);
    `CHK("back", 2'h0, pst)
    hrst_n = 0;
    cyc(8);
    hrst_n = 1;
    cyc(8);
    `CHK("hard pd", 1'b0, ctl.func_enable)
    rd(0, 8'h0C); `CHK("special kept", 32'h400008, q)
    loop_act = 1;
    wr(0, 8'h0C, 32'h8); cyc(1);
    `CHK("sys gated", 1'b0, ctl.sys_clk_en)
    `CHK("mac gated", 1'b0, ctl.mac_clk_en)
    wr(0, 8'h0C, 32'h10008); cyc(1); `CHK("sys kept", 1'b1, ctl.sys_clk_en)
    give_verdict();
  end
endmodule
